// ==== verilog/dda_core.sv ====
module dda_core
  import dda_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  output logic             busy
);

  // ****************************************
  // architectural state
  // ****************************************
  logic [7:0]  w_r;
  logic [4:0]  stat_r;
  logic [3:0]  bank_r;
  logic [11:0] idx_r;
  logic        ext_r;
  logic [11:0] maddr_r;
  logic [15:0] instr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        busy_r;
  logic [11:0] ea_r;
  logic [7:0]  opnd_r;
  logic [7:0]  res_r;
  logic [4:0]  flags_r;
  logic [7:0]  mem_r [DDA_MEM_DEPTH];
  dda_state_t  state_r;
  dda_state_t  state_nxt;

  logic        is_dec;
  logic        is_adj;
  logic        acc_sel;
  logic        to_file;
  logic [7:0]  fa;
  logic [11:0] ea_nxt;
  logic [7:0]  dec_res;
  logic [4:0]  dec_flags;
  logic [7:0]  adj_res;
  logic        adj_c;
  logic        wr_ok;

  assign is_dec  = (instr_r[15:10] == DDA_DECREMENT_TOP);
  assign is_adj  = (instr_r == DDA_DECIMAL_ADJ);
  assign acc_sel = instr_r[DDA_ACC_BIT];
  assign to_file = instr_r[DDA_DEST_BIT];
  assign fa      = instr_r[7:0];
  // bus writes are dropped while an instruction runs, so state has one writer
  assign wr_ok   = wr_en && !busy_r;

  // ****************************************
  // effective address
  // ****************************************
  always_comb begin
    if (acc_sel) begin
      ea_nxt = {bank_r, fa};
    end else if (ext_r && fa <= DDA_ACC_LIMIT) begin
      ea_nxt = idx_r + {4'h0, fa};
    end else if (fa <= DDA_ACC_LIMIT) begin
      ea_nxt = {4'h0, fa};
    end else begin
      ea_nxt = {DDA_SFR_BANK, fa};
    end
  end

  // ****************************************
  // execution units
  // ****************************************
  dda_dec_alu u_dec (
    .opnd  (opnd_r),
    .res   (dec_res),
    .flags (dec_flags)
  );

  dda_dec_adj u_adj (
    .w_in  (w_r),
    .c_in  (stat_r[DDA_C_BIT]),
    .digc_in (stat_r[DDA_DIGC_BIT]),
    .w_out (adj_res),
    .c_out (adj_c)
  );

  // ****************************************
  // q-cycle sequencer
  // ****************************************
  always_comb begin
    case (state_r)
      DDA_IDLE: state_nxt = (wr_ok && addr == DDA_OFS_INSTR) ? DDA_Q1 : DDA_IDLE;
      DDA_Q1:   state_nxt = DDA_Q2;
      DDA_Q2:   state_nxt = DDA_Q3;
      DDA_Q3:   state_nxt = DDA_Q4;
      DDA_Q4:   state_nxt = DDA_IDLE;
      default:  state_nxt = DDA_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= DDA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != DDA_IDLE);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      instr_r <= 16'h0000;
    end else if (wr_ok && addr == DDA_OFS_INSTR) begin
      instr_r <= wdata[15:0];
    end
  end

  // q1 decode: address formed
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ea_r <= 12'h000;
    end else if (state_r == DDA_Q1) begin
      ea_r <= ea_nxt;
    end
  end

  // q2 read: operand fetched
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      opnd_r <= 8'h00;
    end else if (state_r == DDA_Q2) begin
      opnd_r <= mem_r[ea_r];
    end
  end

  // q3 process: result captured
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      res_r   <= 8'h00;
      flags_r <= DDA_STAT_RST;
    end else if (state_r == DDA_Q3) begin
      res_r   <= dec_res;
      flags_r <= dec_flags;
    end
  end

  // ****************************************
  // q4 write-back
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      w_r <= DDA_W_RST;
    end else if (state_r == DDA_Q4 && is_dec && !to_file) begin
      w_r <= res_r;
    end else if (state_r == DDA_Q4 && is_adj) begin
      w_r <= adj_res;
    end else if (wr_ok && addr == DDA_OFS_WREG) begin
      w_r <= wdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= DDA_STAT_RST;
    end else if (state_r == DDA_Q4 && is_dec) begin
      stat_r <= flags_r;
    end else if (state_r == DDA_Q4 && is_adj) begin
      stat_r[DDA_C_BIT] <= adj_c;
    end else if (wr_ok && addr == DDA_OFS_STAT) begin
      stat_r <= wdata[4:0];
    end
  end

  // no reset on the array: contents are undefined until software loads them
  always_ff @(posedge mclk) begin
    if (state_r == DDA_Q4 && is_dec && to_file) begin
      mem_r[ea_r] <= res_r;
    end else if (wr_ok && addr == DDA_OFS_MDATA) begin
      mem_r[maddr_r] <= wdata[7:0];
    end
  end

  // ****************************************
  // software-only registers
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bank_r  <= DDA_BANK_RST;
      idx_r   <= DDA_IDX_RST;
      ext_r   <= 1'b0;
      maddr_r <= 12'h000;
    end else if (wr_ok) begin
      if (addr == DDA_OFS_BANK) begin
        bank_r <= wdata[3:0];
      end
      if (addr == DDA_OFS_IDX) begin
        idx_r <= wdata[11:0];
      end
      if (addr == DDA_OFS_CTRL) begin
        ext_r <= wdata[DDA_EXT_BIT];
      end
      if (addr == DDA_OFS_MADDR) begin
        maddr_r <= wdata[11:0];
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    case (addr)
      DDA_OFS_WREG:  rdata_nxt = {24'h000000, w_r};
      DDA_OFS_STAT:  rdata_nxt = {27'h0000000, stat_r};
      DDA_OFS_BANK:  rdata_nxt = {28'h0000000, bank_r};
      DDA_OFS_IDX:   rdata_nxt = {20'h00000, idx_r};
      DDA_OFS_CTRL:  rdata_nxt = {31'h00000000, ext_r};
      DDA_OFS_MADDR: rdata_nxt = {20'h00000, maddr_r};
      DDA_OFS_MDATA: rdata_nxt = {24'h000000, mem_r[maddr_r]};
      DDA_OFS_INSTR: rdata_nxt = {16'h0000, instr_r};
      DDA_OFS_STATE: rdata_nxt = {28'h0000000, busy_r, state_r};
      default:       rdata_nxt = 32'h00000000;
    endcase
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h00000000;
    end else if (rd_en) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign rdata = rdata_r;
  assign busy  = busy_r;

endmodule

// ==== verilog/dda_pkg.sv ====
// Notes on behaviour
// - decrement instruction writes addressed register value minus one to its destination.
// - destination bit 0 sends result to working register, 1 writes it back.
// - access bit 0 selects access bank; 1 uses bank selector for the bank.
// - extended set with access bit 0 and address up to 95 uses indexed offset.
// - decimal adjust corrects each nibble by six as needed and updates carry.
package dda_pkg;

  // ****************************************
  // register bus map
  // ****************************************
  localparam logic [7:0] DDA_OFS_WREG  = 8'h00;
  localparam logic [7:0] DDA_OFS_STAT  = 8'h04;
  localparam logic [7:0] DDA_OFS_BANK  = 8'h08;
  localparam logic [7:0] DDA_OFS_IDX   = 8'h0C;
  localparam logic [7:0] DDA_OFS_CTRL  = 8'h10;
  localparam logic [7:0] DDA_OFS_MADDR = 8'h14;
  localparam logic [7:0] DDA_OFS_MDATA = 8'h18;
  localparam logic [7:0] DDA_OFS_INSTR = 8'h1C;
  localparam logic [7:0] DDA_OFS_STATE = 8'h20;

  // ****************************************
  // status flag positions and reset values
  // ****************************************
  localparam int DDA_C_BIT  = 0;
  localparam int DDA_DIGC_BIT = 1;
  localparam int DDA_Z_BIT  = 2;
  localparam int DDA_OVF_BIT = 3;
  localparam int DDA_N_BIT  = 4;
  localparam int DDA_EXT_BIT = 0;
  localparam logic [4:0]  DDA_STAT_RST = 5'h00;
  localparam logic [7:0]  DDA_W_RST    = 8'h00;
  localparam logic [3:0]  DDA_BANK_RST = 4'h0;
  localparam logic [11:0] DDA_IDX_RST  = 12'h000;

  // ****************************************
  // instruction encodings and addressing
  // ****************************************
  localparam logic [5:0]  DDA_DECREMENT_TOP = 6'h01;
  localparam logic [15:0] DDA_DECIMAL_ADJ   = 16'h0007;
  localparam int          DDA_DEST_BIT      = 9;
  localparam int          DDA_ACC_BIT       = 8;
  localparam logic [7:0]  DDA_ACC_LIMIT     = 8'h5F;
  localparam logic [3:0]  DDA_SFR_BANK      = 4'hF;
  localparam logic [3:0]  DDA_ADJ           = 4'h6;
  localparam logic [3:0]  DDA_DIGIT_MAX     = 4'h9;
  localparam int          DDA_MEM_DEPTH     = 4096;

  typedef enum logic [2:0] {
    DDA_IDLE = 3'h0,
    DDA_Q1   = 3'h1,
    DDA_Q2   = 3'h3,
    DDA_Q3   = 3'h2,
    DDA_Q4   = 3'h6
  } dda_state_t;

endpackage

// ==== verilog/dda_dec_alu.sv ====
module dda_dec_alu
  import dda_pkg::*;
(
  input  wire logic [7:0] opnd,
  output logic      [7:0] res,
  output logic      [4:0] flags
);

  // ****************************************
  // subtract one, flags as a true subtraction
  // ****************************************
  always_comb begin
    res                = opnd - 8'h01;
    flags              = DDA_STAT_RST;
    flags[DDA_C_BIT]   = (opnd != 8'h00);
    flags[DDA_DIGC_BIT] = (opnd[3:0] != 4'h0);
    flags[DDA_Z_BIT]   = (res == 8'h00);
    flags[DDA_OVF_BIT] = (opnd == 8'h80);
    flags[DDA_N_BIT]   = res[7];
  end

endmodule

// ==== verilog/dda_dec_adj.sv ====
module dda_dec_adj
  import dda_pkg::*;
(
  input  wire logic [7:0] w_in,
  input  wire logic       c_in,
  input  wire logic       digc_in,
  output logic      [7:0] w_out,
  output logic            c_out
);

  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic       dig_c;

  // ****************************************
  // nibble correction
  // ****************************************
  // low nibble carry feeds the high nibble, else a packed 5+5 sum would be off
  always_comb begin
    lo_sum = {1'b0, w_in[3:0]};
    if (w_in[3:0] > DDA_DIGIT_MAX || digc_in) begin
      lo_sum = {1'b0, w_in[3:0]} + {1'b0, DDA_ADJ};
    end
    dig_c  = lo_sum[4];
    hi_sum = {1'b0, w_in[7:4]} + {4'h0, dig_c};
    if (hi_sum > {1'b0, DDA_DIGIT_MAX} || c_in) begin
      hi_sum = hi_sum + {1'b0, DDA_ADJ};
    end
    w_out = {hi_sum[3:0], lo_sum[3:0]};
    c_out = c_in | hi_sum[4];
  end

endmodule

// ==== testbench/dda_core_properties.sv ====
module dda_core_chk
  import dda_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire logic        busy
);
  // ****************************************
  // port relations
  // ****************************************
  default clocking chk_cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_rd_idle; !rd_en |=> rdata == 32'h0; endproperty
  property p_start; wr_en && addr == DDA_OFS_INSTR && !busy |=> busy; endproperty
  property p_len; $rose(busy) |-> busy[*4] ##1 !busy; endproperty
  property p_cause; $rose(busy) |-> $past(wr_en) && $past(addr) == DDA_OFS_INSTR; endproperty
  property p_state; rd_en && addr == DDA_OFS_STATE |=> rdata[3] == $past(busy) && rdata[31:4] == 28'h0; endproperty
  property p_unmap; rd_en && addr == 8'hFC |=> rdata == 32'h0; endproperty
  property p_stat; rd_en && addr == DDA_OFS_STAT |=> rdata[31:5] == 27'h0; endproperty
  // write then read back checks the register really latches
  property p_wecho;
    wr_en && addr == DDA_OFS_WREG && !busy ##1 rd_en && addr == DDA_OFS_WREG |=> rdata[7:0] == $past(wdata[7:0], 2);
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("rdata nonzero without read");
  a_start: assert property (p_start) else $error("busy did not start");
  a_len: assert property (p_len) else $error("busy length wrong");
  a_cause: assert property (p_cause) else $error("busy rose without start");
  a_state: assert property (p_state) else $error("state word wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_stat: assert property (p_stat) else $error("status upper bits set");
  a_wecho: assert property (p_wecho) else $error("working register echo wrong");

  c_run: cover property (p_len);
  c_echo: cover property (p_wecho);
  c_state: cover property (rd_en && addr == DDA_OFS_STATE && busy);
endmodule

bind dda_core dda_core_chk u_chk (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .busy(busy));

// ==== testbench/tb_dda_core.sv ====
module tb_dda_core
  import dda_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rstn, wr_en, rd_en, rd_q;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        busy;
  logic [31:0] expq[$];
  int          mismatches, compares;

  dda_core dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .busy(busy));

  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  // strobes never drop inside a task, so no double assignment per edge
  task automatic bus(input int m, input logic [7:0] a, input logic [31:0] d);
    wr_en <= (m == 1);
    rd_en <= (m == 2);
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(2, a, 32'h0);
  endtask

  // state read and W write land while busy; the write must be dropped
  task automatic exec(input logic [15:0] op);
    int n;
    bus(1, DDA_OFS_INSTR, {16'h0, op});
    rd(DDA_OFS_STATE, 32'h9);
    bus(1, DDA_OFS_WREG, 32'hEE);
    bus(0, 8'h0, 32'h0);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      close_out();
    end
  endtask

  function automatic logic [8:0] bcd_fix(input logic [7:0] w, input logic c, input logic digc);
    logic [4:0] lo, hi;
    lo = {1'b0, w[3:0]} + ((w[3:0] > 4'h9 || digc) ? 5'h06 : 5'h00);
    hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
    if (hi > 5'h09 || c) hi = hi + 5'h06;
    return {c | hi[4], hi[3:0], lo[3:0]};
  endfunction

  task automatic close_out();
    $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge mclk) begin
    if (rd_q) begin
      compares++;
      if (rdata !== expq[0]) begin
        mismatches++;
        $display("Error at %0t: got %h exp %h", $time, rdata, expq[0]);
      end
      void'(expq.pop_front());
    end
    rd_q <= rd_en;
  end

  // ****************************************
  // tests
  // ****************************************
  logic [7:0]  ex[2] = '{8'hA5, 8'hCE};
  logic [7:0]  vals[4] = '{8'h00, 8'h01, 8'h80, 8'h10};
  logic [7:0]  f, v, r, w0;
  logic [3:0]  bk;
  logic [11:0] ix, ma;
  logic        d, a, ext;
  logic [8:0]  dj;
  logic [4:0]  s;
  logic [7:0]  regs[7] = '{DDA_OFS_WREG, DDA_OFS_STAT, DDA_OFS_BANK, DDA_OFS_IDX, DDA_OFS_CTRL, DDA_OFS_STATE, 8'hFC};

  initial begin
    {wr_en, rd_en, addr, wdata} <= '0;
    mismatches = 0;
    compares = 0;
    void'($urandom(50963));
    for (int k = 0; k < 2; k++) begin
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      foreach (regs[i]) rd(regs[i], 32'h0);
      bus(1, DDA_OFS_WREG, {24'h0, ex[k]});
      rd(DDA_OFS_WREG, {24'h0, ex[k]});
      exec(16'h0000);
      exec(DDA_DECIMAL_ADJ);
      dj = bcd_fix(ex[k], 1'b0, 1'b0);
      rd(DDA_OFS_WREG, {24'h0, dj[7:0]});
      rd(DDA_OFS_STAT, {27'h0, 4'h0, dj[8]});
      $display("test adjust example %0d done", k);
      // drop the read strobe so the last result is checked before reset clears it
      bus(0, 8'h0, 32'h0);
    end
    for (int i = 0; i < 16; i++) begin
      {ext, a, d} = i[2:0];
      f  = i[3] ? 8'h60 + 8'($urandom_range(159)) : 8'($urandom_range(95));
      v  = (i > 11) ? 8'($urandom) : vals[(i + (i >> 2)) & 3];
      bk = 4'($urandom);
      ix = 12'($urandom);
      w0 = 8'($urandom);
      ma = a ? {bk, f} : (f <= DDA_ACC_LIMIT ? (ext ? ix + {4'h0, f} : {4'h0, f}) : {DDA_SFR_BANK, f});
      bus(1, DDA_OFS_BANK, {28'h0, bk});
      bus(1, DDA_OFS_IDX, {20'h0, ix});
      bus(1, DDA_OFS_CTRL, {31'h0, ext});
      bus(1, DDA_OFS_WREG, {24'h0, w0});
      bus(1, DDA_OFS_MADDR, {20'h0, ma});
      bus(1, DDA_OFS_MDATA, {24'h0, v});
      exec({DDA_DECREMENT_TOP, d, a, f});
      r = v - 8'h01;
      s = {r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00};
      rd(DDA_OFS_WREG, {24'h0, d ? w0 : r});
      rd(DDA_OFS_MDATA, {24'h0, d ? r : v});
      rd(DDA_OFS_STAT, {27'h0, s});
      if (!d) begin
        exec(DDA_DECIMAL_ADJ);
        dj = bcd_fix(r, s[0], s[1]);
        rd(DDA_OFS_WREG, {24'h0, dj[7:0]});
        rd(DDA_OFS_STAT, {27'h0, s[4:1], dj[8]});
      end
      $display("test decrement %0d done", i);
    end
    bus(0, 8'h0, 32'h0);
    repeat (2) @(posedge mclk);
    close_out();
  end
endmodule
